// >>> common/mmbd_pkg.sv
// constants and state type for the memory map and bank decode block
package mmbd_pkg;

	// ************************************************************
	// widths
	// ************************************************************
	localparam int PC_W        = 13;
	localparam int FETCH_W     = 10;
	localparam int INSTR_W     = 14;
	localparam int FILE_W      = 7;
	localparam int DADDR_W     = 8;
	localparam int BYTE_W      = 8;
	localparam int GPR_DEPTH   = 64;
	localparam int SFR_DEPTH   = 64;
	localparam int SFR_IDX_W   = 6;
	localparam int GPR_IDX_W   = 6;

	// ************************************************************
	// program space
	// ************************************************************
	localparam logic [PC_W-1:0]  RESET_VECTOR  = 13'h0000;
	localparam logic [PC_W-1:0]  IRQ_VECTOR    = 13'h0004;
	localparam logic [PC_W-1:0]  PC_STEP       = 13'h0001;
	localparam logic [PC_W-1:0]  PROG_LAST     = 13'h03ff;

	// ************************************************************
	// data space layout
	// ************************************************************
	localparam logic [FILE_W-1:0] GPR_FIRST     = 7'h20;
	localparam logic [FILE_W-1:0] GPR_LAST      = 7'h5f;
	localparam int                BANK_BIT_POS  = 5;
	localparam logic [BYTE_W-1:0] STATUS_RESET  = 8'h18;
	localparam logic [BYTE_W-1:0] ZERO_BYTE     = 8'h00;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [DADDR_W-1:0] OFS_INDIRECT_ACCESS_BANK0    = 8'h00;
	localparam logic [DADDR_W-1:0] OFS_TIMER0_COUNT             = 8'h01;
	localparam logic [DADDR_W-1:0] OFS_PC_LOW_BYTE              = 8'h02;
	localparam logic [DADDR_W-1:0] OFS_STATUS_FLAGS_BANK0       = 8'h03;
	localparam logic [DADDR_W-1:0] OFS_INDIRECT_POINTER         = 8'h04;
	localparam logic [DADDR_W-1:0] OFS_PORT_A_PINS              = 8'h05;
	localparam logic [DADDR_W-1:0] OFS_PORT_C_PINS              = 8'h07;
	localparam logic [DADDR_W-1:0] OFS_PC_HIGH_LATCH            = 8'h0a;
	localparam logic [DADDR_W-1:0] OFS_INTERRUPT_CONTROL        = 8'h0b;
	localparam logic [DADDR_W-1:0] OFS_PERIPHERAL_IRQ_FLAGS     = 8'h0c;
	localparam logic [DADDR_W-1:0] OFS_TIMER1_COUNT_LOW         = 8'h0e;
	localparam logic [DADDR_W-1:0] OFS_TIMER1_COUNT_HIGH        = 8'h0f;
	localparam logic [DADDR_W-1:0] OFS_TIMER1_CONTROL           = 8'h10;
	localparam logic [DADDR_W-1:0] OFS_COMPARATOR_CONTROL       = 8'h19;
	localparam logic [DADDR_W-1:0] OFS_ADC_RESULT_HIGH          = 8'h1e;
	localparam logic [DADDR_W-1:0] OFS_ADC_CONTROL_FIRST        = 8'h1f;
	localparam logic [DADDR_W-1:0] OFS_INDIRECT_ACCESS_BANK1    = 8'h80;
	localparam logic [DADDR_W-1:0] OFS_PRESCALER_OPTION_CONFIG  = 8'h81;
	localparam logic [DADDR_W-1:0] OFS_PC_LOW_BYTE_MIRROR       = 8'h82;
	localparam logic [DADDR_W-1:0] OFS_STATUS_FLAGS_BANK1       = 8'h83;
	localparam logic [DADDR_W-1:0] OFS_INDIRECT_POINTER_MIRROR  = 8'h84;
	localparam logic [DADDR_W-1:0] OFS_PORT_A_DIRECTION         = 8'h85;
	localparam logic [DADDR_W-1:0] OFS_PORT_C_DIRECTION         = 8'h87;
	localparam logic [DADDR_W-1:0] OFS_PC_HIGH_LATCH_MIRROR     = 8'h8a;
	localparam logic [DADDR_W-1:0] OFS_INTERRUPT_CONTROL_MIRROR = 8'h8b;
	localparam logic [DADDR_W-1:0] OFS_PERIPHERAL_IRQ_ENABLES   = 8'h8c;
	localparam logic [DADDR_W-1:0] OFS_POWER_CONTROL_FLAGS      = 8'h8e;
	localparam logic [DADDR_W-1:0] OFS_OSCILLATOR_TRIM          = 8'h90;
	localparam logic [DADDR_W-1:0] OFS_ANALOG_PIN_SELECT        = 8'h91;
	localparam logic [DADDR_W-1:0] OFS_PORT_A_PULLUPS           = 8'h95;
	localparam logic [DADDR_W-1:0] OFS_PORT_A_CHANGE_ENABLES    = 8'h96;
	localparam logic [DADDR_W-1:0] OFS_VOLTAGE_REF_CONTROL      = 8'h99;
	localparam logic [DADDR_W-1:0] OFS_NVM_DATA                 = 8'h9a;
	localparam logic [DADDR_W-1:0] OFS_NVM_ADDRESS              = 8'h9b;
	localparam logic [DADDR_W-1:0] OFS_NVM_CONTROL_FIRST        = 8'h9c;
	localparam logic [DADDR_W-1:0] OFS_NVM_UNLOCK               = 8'h9d;
	localparam logic [DADDR_W-1:0] OFS_ADC_RESULT_LOW           = 8'h9e;
	localparam logic [DADDR_W-1:0] OFS_ADC_CONTROL_SECOND       = 8'h9f;

	// ************************************************************
	// state of the decode block
	// ************************************************************
	typedef struct packed {
		logic [PC_W-1:0]                  pc;
		logic [FETCH_W-1:0]               fetch_addr;
		logic [BYTE_W-1:0]                rdata;
		logic                             rd_valid;
		logic [BYTE_W-1:0]                periph_rdata;
		logic                             bank_sel;
		logic [GPR_DEPTH-1:0][BYTE_W-1:0] general_purpose_ram;
		logic [SFR_DEPTH-1:0][BYTE_W-1:0] special_function_register;
	} mmbd_state_t;

endpackage : mmbd_pkg

// >>> verilog/mmbd_decode.sv
// program and data memory address decode with banked register file
module mmbd_decode (
	input  wire logic                           core_clk_in,
	input  wire logic                           rst_b_in,
	// program counter control from the core
	input  wire logic                           pc_step_in,
	input  wire logic                           pc_jump_in,
	input  wire logic [mmbd_pkg::PC_W-1:0]      pc_jump_target_in,
	input  wire logic                           irq_take_in,
	output logic      [mmbd_pkg::PC_W-1:0]      program_counter_out,
	output logic      [mmbd_pkg::FETCH_W-1:0]   fetch_addr_out,
	// file access from the core
	input  wire logic                           file_rd_in,
	input  wire logic                           file_wr_in,
	input  wire logic [mmbd_pkg::FILE_W-1:0]    file_addr_in,
	input  wire logic [mmbd_pkg::BYTE_W-1:0]    file_wdata_in,
	output logic      [mmbd_pkg::BYTE_W-1:0]    file_rdata_out,
	output logic                                file_rd_valid_out,
	output logic                                bank_select_bit_out,
	// peripheral side of the special-function registers
	input  wire logic                           periph_wr_in,
	input  wire logic [mmbd_pkg::DADDR_W-1:0]   periph_addr_in,
	input  wire logic [mmbd_pkg::BYTE_W-1:0]    periph_wdata_in,
	output logic      [mmbd_pkg::BYTE_W-1:0]    periph_rdata_out
);
	import mmbd_pkg::*;

	// ************************************************************
	// decode functions
	// ************************************************************

	// core registers that appear in both banks share one storage slot
	function automatic logic is_shared_sfr(input logic [DADDR_W-1:0] a);
		logic [DADDR_W-1:0] lo;
		lo = {1'b0, a[FILE_W-1:0]};
		case (lo)
			OFS_PC_LOW_BYTE,
			OFS_STATUS_FLAGS_BANK0,
			OFS_INDIRECT_POINTER,
			OFS_PC_HIGH_LATCH,
			OFS_INTERRUPT_CONTROL: begin
				is_shared_sfr = 1'b1;
			end
			default: begin
				is_shared_sfr = 1'b0;
			end
		endcase
	endfunction : is_shared_sfr

	function automatic logic [SFR_IDX_W-1:0] sfr_index(input logic [DADDR_W-1:0] a);
		if (is_shared_sfr(a)) begin
			sfr_index = {1'b0, a[4:0]};
		end else begin
			sfr_index = {a[DADDR_W-1], a[4:0]};
		end
	endfunction : sfr_index

	// locations that have storage behind them; the indirect slots do not
	function automatic logic sfr_implemented(input logic [DADDR_W-1:0] a);
		case (a)
			OFS_TIMER0_COUNT,
			OFS_PC_LOW_BYTE,
			OFS_STATUS_FLAGS_BANK0,
			OFS_INDIRECT_POINTER,
			OFS_PORT_A_PINS,
			OFS_PORT_C_PINS,
			OFS_PC_HIGH_LATCH,
			OFS_INTERRUPT_CONTROL,
			OFS_PERIPHERAL_IRQ_FLAGS,
			OFS_TIMER1_COUNT_LOW,
			OFS_TIMER1_COUNT_HIGH,
			OFS_TIMER1_CONTROL,
			OFS_COMPARATOR_CONTROL,
			OFS_ADC_RESULT_HIGH,
			OFS_ADC_CONTROL_FIRST,
			OFS_PRESCALER_OPTION_CONFIG,
			OFS_PC_LOW_BYTE_MIRROR,
			OFS_STATUS_FLAGS_BANK1,
			OFS_INDIRECT_POINTER_MIRROR,
			OFS_PORT_A_DIRECTION,
			OFS_PORT_C_DIRECTION,
			OFS_PC_HIGH_LATCH_MIRROR,
			OFS_INTERRUPT_CONTROL_MIRROR,
			OFS_PERIPHERAL_IRQ_ENABLES,
			OFS_POWER_CONTROL_FLAGS,
			OFS_OSCILLATOR_TRIM,
			OFS_ANALOG_PIN_SELECT,
			OFS_PORT_A_PULLUPS,
			OFS_PORT_A_CHANGE_ENABLES,
			OFS_VOLTAGE_REF_CONTROL,
			OFS_NVM_DATA,
			OFS_NVM_ADDRESS,
			OFS_NVM_CONTROL_FIRST,
			OFS_NVM_UNLOCK,
			OFS_ADC_RESULT_LOW,
			OFS_ADC_CONTROL_SECOND: begin
				sfr_implemented = 1'b1;
			end
			default: begin
				sfr_implemented = 1'b0;
			end
		endcase
	endfunction : sfr_implemented

	function automatic logic is_gpr(input logic [DADDR_W-1:0] a);
		is_gpr = (a[FILE_W-1:0] >= GPR_FIRST) && (a[FILE_W-1:0] <= GPR_LAST);
	endfunction : is_gpr

	function automatic logic is_sfr_space(input logic [DADDR_W-1:0] a);
		is_sfr_space = (a[6:5] == 2'b00);
	endfunction : is_sfr_space

	function automatic logic [GPR_IDX_W-1:0] gpr_index(input logic [DADDR_W-1:0] a);
		logic [FILE_W-1:0] off;
		off = a[FILE_W-1:0] - GPR_FIRST;
		gpr_index = off[GPR_IDX_W-1:0];
	endfunction : gpr_index

	// the pc low byte reads back the live counter, not a stored copy
	function automatic logic is_pcl(input logic [DADDR_W-1:0] a);
		is_pcl = ({1'b0, a[FILE_W-1:0]} == OFS_PC_LOW_BYTE);
	endfunction : is_pcl

	// storage that core and peripheral reads may return
	function automatic logic sfr_readable(input logic [DADDR_W-1:0] a);
		sfr_readable = is_sfr_space(a) && sfr_implemented(a);
	endfunction : sfr_readable

	// a core write to pcl moves the pc instead of landing in storage
	function automatic logic sfr_writable(input logic [DADDR_W-1:0] a);
		sfr_writable = sfr_readable(a) && !is_pcl(a);
	endfunction : sfr_writable

	// ************************************************************
	// state
	// ************************************************************
	mmbd_state_t st_r;
	mmbd_state_t st_nxt;

	logic [DADDR_W-1:0] direct_addr;
	logic [DADDR_W-1:0] eff_addr;
	logic               via_pointer;
	logic [BYTE_W-1:0]  pointer_val;
	logic [BYTE_W-1:0]  pc_high_latch_val;
	logic               core_write_ok;
	logic               pcl_write;

	always_comb begin
		pointer_val = st_r.special_function_register[sfr_index(OFS_INDIRECT_POINTER)];
		pc_high_latch_val  = st_r.special_function_register[sfr_index(OFS_PC_HIGH_LATCH)];
		direct_addr = {st_r.bank_sel, file_addr_in};
		// file address zero goes through the pointer in either bank
		via_pointer = (file_addr_in == OFS_INDIRECT_ACCESS_BANK0[FILE_W-1:0]);
		// full 8-bit pointer; the upper bank bit is reserved so no ninth bit
		eff_addr    = via_pointer ? pointer_val : direct_addr;
		// an indirect access that points back at the indirect slot does nothing
		core_write_ok = file_wr_in && !(via_pointer &&
			(eff_addr[FILE_W-1:0] == OFS_INDIRECT_ACCESS_BANK0[FILE_W-1:0]));
		pcl_write   = core_write_ok && is_pcl(eff_addr);
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.rd_valid = 1'b0;

		// program counter: interrupt outranks a jump, a jump a pcl write
		if (irq_take_in) begin
			st_nxt.pc = IRQ_VECTOR;
		end else if (pc_jump_in) begin
			st_nxt.pc = pc_jump_target_in;
		end else if (pcl_write) begin
			st_nxt.pc = {pc_high_latch_val[4:0], file_wdata_in};
		end else if (pc_step_in) begin
			st_nxt.pc = st_r.pc + PC_STEP;
		end
		// high bits have no storage, so the fetch folds into the low 1K
		st_nxt.fetch_addr = st_nxt.pc[FETCH_W-1:0];

		// core read, answered one cycle later
		if (file_rd_in) begin
			st_nxt.rd_valid = 1'b1;
			if (via_pointer && (eff_addr[FILE_W-1:0] == 7'h00)) begin
				st_nxt.rdata = ZERO_BYTE;
			end else if (is_gpr(eff_addr)) begin
				st_nxt.rdata = st_r.general_purpose_ram[gpr_index(eff_addr)];
			end else if (is_pcl(eff_addr)) begin
				st_nxt.rdata = st_r.pc[BYTE_W-1:0];
			end else if (sfr_readable(eff_addr) && (eff_addr != OFS_NVM_UNLOCK)) begin
				// the unlock slot is write-only to the core; only a peripheral read returns its stored byte
				st_nxt.rdata = st_r.special_function_register[sfr_index(eff_addr)];
			end else begin
				st_nxt.rdata = ZERO_BYTE;
			end
		end

		// core write
		if (core_write_ok) begin
			if (is_gpr(eff_addr)) begin
				st_nxt.general_purpose_ram[gpr_index(eff_addr)] = file_wdata_in;
			end else if (sfr_writable(eff_addr)) begin
				st_nxt.special_function_register[sfr_index(eff_addr)] = file_wdata_in;
			end
		end

		// peripheral write lands after the core's, so it wins a collision
		if (periph_wr_in && sfr_writable(periph_addr_in)) begin
			st_nxt.special_function_register[sfr_index(periph_addr_in)] = periph_wdata_in;
		end

		if (is_pcl(periph_addr_in)) begin
			st_nxt.periph_rdata = st_r.pc[BYTE_W-1:0];
		end else if (sfr_readable(periph_addr_in)) begin
			st_nxt.periph_rdata = st_r.special_function_register[sfr_index(periph_addr_in)];
		end else begin
			st_nxt.periph_rdata = ZERO_BYTE;
		end

		// bits 7:6 are stored as written; keeping them zero is software's job
		st_nxt.bank_sel = st_nxt.special_function_register[sfr_index(OFS_STATUS_FLAGS_BANK0)][BANK_BIT_POS];
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_r.pc           <= RESET_VECTOR;
			st_r.fetch_addr   <= RESET_VECTOR[FETCH_W-1:0];
			st_r.rdata        <= ZERO_BYTE;
			st_r.rd_valid     <= 1'b0;
			st_r.periph_rdata <= ZERO_BYTE;
			// bank 0 follows from the status reset value
			st_r.bank_sel     <= STATUS_RESET[BANK_BIT_POS];
			st_r.general_purpose_ram          <= '0;
			st_r.special_function_register          <= '0;
			st_r.special_function_register[OFS_STATUS_FLAGS_BANK0[SFR_IDX_W-1:0]] <= STATUS_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign program_counter_out = st_r.pc;
	assign fetch_addr_out      = st_r.fetch_addr;
	assign file_rdata_out      = st_r.rdata;
	assign file_rd_valid_out   = st_r.rd_valid;
	assign bank_select_bit_out = st_r.bank_sel;
	assign periph_rdata_out    = st_r.periph_rdata;

endmodule : mmbd_decode

// >>> dv/mmbd_decode_assertions.sv
// port-level checks for the memory map and bank decode block
module mmbd_decode_assertions (
	input wire logic                         core_clk_in,
	input wire logic                         rst_b_in,
	input wire logic                         pc_step_in,
	input wire logic                         pc_jump_in,
	input wire logic [mmbd_pkg::PC_W-1:0]    pc_jump_target_in,
	input wire logic                         irq_take_in,
	input wire logic [mmbd_pkg::PC_W-1:0]    program_counter_out,
	input wire logic [mmbd_pkg::FETCH_W-1:0] fetch_addr_out,
	input wire logic                         file_rd_in,
	input wire logic                         file_wr_in,
	input wire logic [mmbd_pkg::FILE_W-1:0]  file_addr_in,
	input wire logic [mmbd_pkg::BYTE_W-1:0]  file_wdata_in,
	input wire logic [mmbd_pkg::BYTE_W-1:0]  file_rdata_out,
	input wire logic                         file_rd_valid_out,
	input wire logic                         bank_select_bit_out,
	input wire logic                         periph_wr_in,
	input wire logic [mmbd_pkg::DADDR_W-1:0] periph_addr_in,
	input wire logic [mmbd_pkg::BYTE_W-1:0]  periph_wdata_in,
	input wire logic [mmbd_pkg::BYTE_W-1:0]  periph_rdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import mmbd_pkg::*;
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_b_in);

	property p_rd_pulse; file_rd_in |=> file_rd_valid_out; endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read not answered");
	property p_rd_quiet; !file_rd_in |=> !file_rd_valid_out; endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("spurious read valid");
	property p_irq; irq_take_in |=> program_counter_out == IRQ_VECTOR; endproperty
	a_irq: assert property (p_irq) else $error("interrupt vector wrong");
	property p_wrap; fetch_addr_out == program_counter_out[FETCH_W-1:0]; endproperty
	a_wrap: assert property (p_wrap) else $error("fetch address not wrapped");
	// pcl writes also move the pc, so any write cycle is left out
	property p_step;
		pc_step_in && !pc_jump_in && !irq_take_in && !file_wr_in && !periph_wr_in
		|=> program_counter_out == $past(program_counter_out) + PC_STEP;
	endproperty
	a_step: assert property (p_step) else $error("pc step wrong");
	property p_jump; pc_jump_in && !irq_take_in |=> program_counter_out == $past(pc_jump_target_in);
	endproperty
	a_jump: assert property (p_jump) else $error("pc jump wrong");
	property p_bank;
		file_wr_in && file_addr_in == 7'h03 && !periph_wr_in
		|=> bank_select_bit_out == $past(file_wdata_in[BANK_BIT_POS]);
	endproperty
	a_bank: assert property (p_bank) else $error("bank bit not taken");
	property p_rst_pc; $rose(rst_b_in) |-> program_counter_out == RESET_VECTOR; endproperty
	a_rst_pc: assert property (p_rst_pc) else $error("pc not cleared by reset");
	property p_unimp; file_rd_in && file_addr_in > GPR_LAST |=> file_rdata_out == ZERO_BYTE;
	endproperty
	a_unimp: assert property (p_unimp) else $error("unimplemented read not zero");
	c_irq: cover property (irq_take_in);
	c_bank1: cover property ($rose(bank_select_bit_out));
	c_unimp: cover property (file_rd_in && file_addr_in > GPR_LAST);
endmodule : mmbd_decode_assertions

bind mmbd_decode mmbd_decode_assertions u_mmbd_decode_assertions (
	.core_clk_in, .rst_b_in, .pc_step_in, .pc_jump_in, .pc_jump_target_in, .irq_take_in,
	.program_counter_out, .fetch_addr_out, .file_rd_in, .file_wr_in, .file_addr_in,
	.file_wdata_in, .file_rdata_out, .file_rd_valid_out, .bank_select_bit_out,
	.periph_wr_in, .periph_addr_in, .periph_wdata_in, .periph_rdata_out
);

// >>> dv/mmbd_core_model.sv
// behavioural processor core issuing file reads and writes
module mmbd_core_model (
	input  wire logic                        core_clk_in,
	output logic                             file_rd_out,
	output logic                             file_wr_out,
	output logic [mmbd_pkg::FILE_W-1:0]      file_addr_out,
	output logic [mmbd_pkg::BYTE_W-1:0]      file_wdata_out,
	input  wire logic [mmbd_pkg::BYTE_W-1:0] file_rdata_in,
	input  wire logic                        file_rd_valid_in
);
	timeunit 1ns;
	timeprecision 1ps;
	import mmbd_pkg::*;
	initial begin
		{file_rd_out, file_wr_out} = 2'h0;
		file_addr_out = 7'h7f;
		file_wdata_out = 8'h00;
	end
	// released address and data are inverted so a stale value never looks valid
	task automatic wr(input logic [FILE_W-1:0] a, input logic [BYTE_W-1:0] d);
		@(negedge core_clk_in);
		{file_addr_out, file_wdata_out, file_wr_out} = {a, d, 1'b1};
		@(negedge core_clk_in);
		{file_addr_out, file_wdata_out, file_wr_out} = {~a, ~d, 1'b0};
	endtask : wr
	task automatic rd(input logic [FILE_W-1:0] a, output logic [BYTE_W-1:0] d, output logic v);
		@(negedge core_clk_in);
		{file_addr_out, file_rd_out} = {a, 1'b1};
		@(negedge core_clk_in);
		{file_addr_out, file_rd_out} = {~a, 1'b0};
		{d, v} = {file_rdata_in, file_rd_valid_in};
	endtask : rd
	task automatic set_bank(input logic b);
		wr(7'h03, {2'h0, b, STATUS_RESET[4:0]});
	endtask : set_bank
endmodule : mmbd_core_model

// >>> dv/mmbd_decode_tb.sv
// self-checking bench for the memory map and bank decode block
module mmbd_decode_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import mmbd_pkg::*;
	logic               core_clk_in, rst_b_in, pc_step_in, pc_jump_in, irq_take_in;
	logic               file_rd_in, file_wr_in, file_rd_valid_out, bank_select_bit_out;
	logic               periph_wr_in;
	logic [PC_W-1:0]    pc_jump_target_in, program_counter_out;
	logic [FETCH_W-1:0] fetch_addr_out;
	logic [FILE_W-1:0]  file_addr_in;
	logic [BYTE_W-1:0]  file_wdata_in, file_rdata_out, periph_wdata_in, periph_rdata_out;
	logic [DADDR_W-1:0] periph_addr_in;
	int                 n_mismatch, checks_done, cycles;

	mmbd_decode u_mmbd_decode (.core_clk_in, .rst_b_in, .pc_step_in, .pc_jump_in,
		.pc_jump_target_in, .irq_take_in, .program_counter_out, .fetch_addr_out, .file_rd_in,
		.file_wr_in, .file_addr_in, .file_wdata_in, .file_rdata_out, .file_rd_valid_out,
		.bank_select_bit_out, .periph_wr_in, .periph_addr_in, .periph_wdata_in, .periph_rdata_out);
	mmbd_core_model u_mmbd_core_model (.core_clk_in, .file_rd_out(file_rd_in),
		.file_wr_out(file_wr_in), .file_addr_out(file_addr_in), .file_wdata_out(file_wdata_in),
		.file_rdata_in(file_rdata_out), .file_rd_valid_in(file_rd_valid_out));

	initial begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end
	task automatic finish_test();
		$display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_byte(input logic [BYTE_W-1:0] got, input logic [BYTE_W-1:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: byte got %h expected %h", $time, got, exp);
		end
	endtask : chk_byte
	task automatic chk_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: bit got %b expected %b", $time, got, exp);
		end
	endtask : chk_bit
	// controls are {step, jump, irq}
	task automatic pc_ctl(input logic [2:0] c, input logic [PC_W-1:0] t, input logic [PC_W-1:0] e);
		@(negedge core_clk_in);
		{pc_step_in, pc_jump_in, irq_take_in, pc_jump_target_in} = {c, t};
		@(negedge core_clk_in);
		{pc_step_in, pc_jump_in, irq_take_in, pc_jump_target_in} = {3'h0, ~t};
		chk(program_counter_out, e);
		chk({3'h0, fetch_addr_out}, {3'h0, e[FETCH_W-1:0]});
	endtask : pc_ctl
	task automatic rd_chk(input logic [FILE_W-1:0] a, input logic [BYTE_W-1:0] e);
		logic [BYTE_W-1:0] d;
		logic v;
		u_mmbd_core_model.rd(a, d, v);
		chk_bit(v, 1'b1);
		chk_byte(d, e);
	endtask : rd_chk
	task automatic t_program();
		chk(program_counter_out, RESET_VECTOR);
		pc_ctl(3'h4, 13'h0000, 13'h0001);
		pc_ctl(3'h2, 13'h0bfe, 13'h0bfe);
		pc_ctl(3'h2, 13'h1fff, 13'h1fff);
		pc_ctl(3'h4, 13'h0000, 13'h0000);
		pc_ctl(3'h7, 13'h0155, IRQ_VECTOR);
	endtask : t_program
	task automatic t_banks();
		rd_chk(7'h03, STATUS_RESET);
		u_mmbd_core_model.wr(7'h25, 8'ha5);
		u_mmbd_core_model.set_bank(1'b1);
		chk_bit(bank_select_bit_out, 1'b1);
		rd_chk(7'h25, 8'ha5);
		u_mmbd_core_model.wr(7'h01, 8'h3c);
		rd_chk(7'h06, ZERO_BYTE);
		u_mmbd_core_model.set_bank(1'b0);
		rd_chk(7'h01, ZERO_BYTE);
		u_mmbd_core_model.wr(7'h60, 8'hff);
		rd_chk(7'h60, ZERO_BYTE);
		rd_chk(7'h1d, ZERO_BYTE);
		u_mmbd_core_model.set_bank(1'b1);
		rd_chk(7'h01, 8'h3c);
		u_mmbd_core_model.wr(7'h1d, 8'h55);
		rd_chk(7'h1d, ZERO_BYTE);
		u_mmbd_core_model.set_bank(1'b0);
	endtask : t_banks
	task automatic t_indirect();
		u_mmbd_core_model.wr(7'h04, 8'h30);
		u_mmbd_core_model.wr(7'h00, 8'h5a);
		rd_chk(7'h30, 8'h5a);
		u_mmbd_core_model.wr(7'h04, 8'hb0);
		rd_chk(7'h00, 8'h5a);
		u_mmbd_core_model.wr(7'h04, 8'he0);
		rd_chk(7'h00, ZERO_BYTE);
	endtask : t_indirect
	task automatic t_periph();
		@(negedge core_clk_in);
		{periph_wr_in, periph_addr_in, periph_wdata_in} = {1'b1, 8'h0e, 8'h77};
		@(negedge core_clk_in);
		{periph_wr_in, periph_wdata_in} = {1'b0, 8'h88};
		rd_chk(7'h0e, 8'h77);
		u_mmbd_core_model.wr(7'h10, 8'h42);
		periph_addr_in = 8'h10;
		@(negedge core_clk_in);
		chk_byte(periph_rdata_out, 8'h42);
		periph_addr_in = OFS_STATUS_FLAGS_BANK1;
		@(negedge core_clk_in);
		chk_byte(periph_rdata_out, STATUS_RESET);
	endtask : t_periph
	// a pcl write loads the pc from the latch and the data byte
	task automatic t_pcl();
		u_mmbd_core_model.wr(7'h0a, 8'h03);
		u_mmbd_core_model.wr(7'h02, 8'h45);
		chk(program_counter_out, 13'h0345);
		chk({3'h0, fetch_addr_out}, 13'h0345);
		rd_chk(7'h02, 8'h45);
	endtask : t_pcl

	// the scenarios need under a hundred cycles, so this ceiling only trips on a hang
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles > 3000) begin
			n_mismatch++;
			finish_test();
		end
	end
	initial begin
		{rst_b_in, pc_step_in, pc_jump_in, irq_take_in, periph_wr_in} = 5'h00;
		{pc_jump_target_in, periph_addr_in, periph_wdata_in} = {13'h0000, 8'h00, 8'h00};
		repeat (5) @(posedge core_clk_in);
		@(negedge core_clk_in);
		rst_b_in = 1'b1;
		t_program();
		t_banks();
		t_indirect();
		t_periph();
		t_pcl();
		finish_test();
	end
endmodule : mmbd_decode_tb
